// file: inc/vpf_pkg.sv
/*
 * Shared constants for the vector pin drive formatter: register map, field
 * positions, reset values, edge indices and the drive format encoding.
 * Assumes an APB master with 32-bit data and byte addresses.
 */
package vpf_pkg;

	// Number of placeable edges per pin.
	localparam int EDGE_N = 8;

	// Edge indices within one vector period.
	localparam logic [2:0] E_EN = 3'h0;
	localparam logic [2:0] E_DAT = 3'h1;
	localparam logic [2:0] E_RET = 3'h2;
	localparam logic [2:0] E_OFF = 3'h3;
	localparam logic [2:0] E_STB = 3'h4;
	localparam logic [2:0] E_DAT2 = 3'h5;
	localparam logic [2:0] E_RET2 = 3'h6;
	localparam logic [2:0] E_STB2 = 3'h7;

	// Drive formats selectable per time set.
	typedef enum logic [1:0]
	{
		non_return_format,
		return_low_format,
		return_high_format,
		complement_surround_format
	} vpf_fmt_t;

	// Register byte offsets.
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_PERIOD = 8'h04;
	localparam logic [7:0] A_EDGE0 = 8'h08;
	localparam logic [7:0] A_STATUS = 8'h28;
	localparam logic [7:0] A_STRIDE = 8'h04;

	// Control and status field positions.
	localparam int CTRL_RUN = 0;
	localparam int CTRL_FMT_LO = 1;
	localparam int CTRL_MULT_LO = 4;
	localparam int STAT_RUN = 16;
	localparam int FAIL_W = 16;

	// Reset values, and the multiplier from which two cycles are packed.
	localparam logic [15:0] PERIOD_RST = 16'h0010;
	localparam logic [3:0] MULT_RST = 4'h1;
	localparam logic [3:0] MULT_TWO = 4'h2;

endpackage

// file: inc/vpf_edge_if.sv
/*
 * Carrier between the formatter and its edge generator: active timing
 * context going down, period start and edge pulses coming back.
 * Assumes both ends share clk_sys.
 */
`timescale 1ns/1ps
interface vpf_edge_if #(parameter int TICK_W = 16);
	import vpf_pkg::*;
	logic run;
	logic [TICK_W-1:0] period;
	logic [EDGE_N-1:0][TICK_W-1:0] edge_time;
	logic start;
	logic [EDGE_N-1:0] fire;
	modport gen (input run, period, edge_time, output start, fire);
	modport fmt (output run, period, edge_time, input start, fire);
endinterface

// file: rtl/vpf_edge_gen.sv
/*
 * Period tick counter and edge comparators of the vector pin drive formatter.
 * Assumes period and edge times are stable from the formatter's registers; it
 * takes a copy of them at every period boundary.
 */
`timescale 1ns/1ps
module vpf_edge_gen #(parameter int TICK_W = 16)
(
	input wire logic clk_sys,
	input wire logic arst_n,
	vpf_edge_if.gen ev
);
	import vpf_pkg::*;

	typedef struct packed
	{
		logic [TICK_W-1:0] cnt;
		logic [TICK_W-1:0] per;
		logic [EDGE_N-1:0][TICK_W-1:0] edg;
		logic start;
		logic [EDGE_N-1:0] fire;
	} vpf_gen_st_t;

	vpf_gen_st_t st_ff;
	vpf_gen_st_t nxt_st;

	////////////////////////////////////////////////////////////////////////////
	// Counts ticks from the period start and fires each edge on a match.
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.start = 1'b0;
		nxt_st.fire = '0;
		if (ev.run)
		begin
			nxt_st.start = (st_ff.cnt == '0);
			for (int i = 0; i < EDGE_N; i++)
			begin
				nxt_st.fire[i] = (st_ff.cnt == st_ff.edg[i]); // see [R15]
			end
			// The context is copied only at the wrap, so a period is never mixed.
			if (({1'b0, st_ff.cnt} + 1'b1) >= {1'b0, st_ff.per})
			begin
				nxt_st.cnt = '0;
				nxt_st.per = ev.period; // see [R11]
				nxt_st.edg = ev.edge_time; // see [R9]
			end
			else
			begin
				nxt_st.cnt = st_ff.cnt + 1'b1;
			end
		end
		else
		begin
			nxt_st.cnt = '0;
			nxt_st.per = ev.period;
			nxt_st.edg = ev.edge_time;
		end
	end

	// Registers the whole state.
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign ev.start = st_ff.start;
	assign ev.fire = st_ff.fire;

	////////////////////////////////////////////////////////////////////////////
	// Checks on the counter.
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	AST_GEN_FIRE: assert property ((ev.run && st_ff.cnt == st_ff.edg[E_RET]) |=> ev.fire[E_RET]) // see [R15]
		else $error("Return edge missed its tick count.");
	AST_GEN_START: assert property ((ev.run && st_ff.cnt == '0) |=> ev.start ##1 !ev.start) // see [R11]
		else $error("Period start pulse wrong.");
	CVR_GEN_TWO: cover property (ev.start ##[1:300] ev.start);
endmodule

// file: rtl/vpf_formatter.sv
/*
 * Per-pin vector drive formatter with an APB register file holding one time
 * set: format, edge multiplier, period and eight edge times.
 * Assumes the pattern sequencer presents the vector on the vec_ ports on
 * clk_sys and takes the next one on vec_take; pin_in comes from the pin.
 */
// Contract
// [R1] A time set selects non-return, return-low, return-high or complement-surround drive.
// [R2] The driver turns on at the enable edge only if the pin was left undriven.
// [R3] In complement-surround format the enable edge starts driving the inverted pattern value.
// [R4] The pin holds its last state until the data edge, then drives the pattern value.
// [R5] At the return edge the pin goes to the return value of the format.
// [R6] The driver turns off at the disable edge when the next vector is non-drive.
// [R7] With two packed cycles the second value is driven at the second data edge.
// [R8] With two packed cycles the second return edge moves the pin to the return value.
// [R9] Eight edges are placeable per pin as offsets from the period start.
// [R10] A time set holds an integer edge multiplier for cycles per period.
// [R11] A time set holds its own period, and all its edges refer to its start.
// [R12] Software updates change only the active context, not stored descriptions.
// [R13] The strobe edge sets when the comparator is sampled and checked.
// [R14] The second strobe edge sets the sampling moment of the second packed cycle.
// [R15] Edge times are tick counts, and an edge fires when the tick counter equals it.
// [R16] Software orders enable, data, return and disable within each cycle.
`timescale 1ns/1ps
module vpf_formatter #(parameter int TICK_W = 16, parameter int MULT_W = 4)
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic vec_drive,
	input wire logic vec_next_drive,
	input wire logic vec_data1,
	input wire logic vec_data2,
	input wire logic vec_cmp_en,
	output logic vec_take,
	input wire logic pin_in,
	output logic pin_out,
	output logic pin_oe,
	output logic cmp_fail
);
	import vpf_pkg::*;

	typedef struct packed
	{
		logic run;
		vpf_fmt_t fmt;
		logic [MULT_W-1:0] mult;
		logic [TICK_W-1:0] period;
		logic [EDGE_N-1:0][TICK_W-1:0] edg;
		logic [FAIL_W-1:0] fail_cnt;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		vpf_fmt_t act_fmt;
		logic [MULT_W-1:0] act_mult;
		logic cur_drv;
		logic nxt_drv;
		logic d1;
		logic d2;
		logic cmp;
		logic pin_meta;
		logic pin_sync;
		logic pin_out;
		logic pin_oe;
		logic fail;
		logic take;
	} vpf_st_t;

	vpf_st_t st_ff;
	vpf_st_t nxt_st;

	vpf_edge_if #(.TICK_W(TICK_W)) ev ();

	////////////////////////////////////////////////////////////////////////////
	// Address decoding helpers.

	// True for an aligned address inside the edge time block.
	function automatic logic is_edge(input logic [7:0] a);
		is_edge = (a >= A_EDGE0) && (a < A_EDGE0 + 8'(EDGE_N) * A_STRIDE) &&
			(a[1:0] == 2'h0);
	endfunction

	// Index of an edge time register.
	function automatic logic [2:0] edge_idx(input logic [7:0] a);
		logic [7:0] d;
		d = a - A_EDGE0;
		edge_idx = d[4:2];
	endfunction

	// True for any mapped register.
	function automatic logic addr_ok(input logic [7:0] a);
		addr_ok = is_edge(a) || a == A_CTRL || a == A_PERIOD || a == A_STATUS;
	endfunction

	// Value the pin returns to after a data edge.
	function automatic logic ret_val(input vpf_fmt_t f, input logic v);
		case (f)
			non_return_format: ret_val = v;
			return_low_format: ret_val = 1'b0;
			return_high_format: ret_val = 1'b1;
			complement_surround_format: ret_val = ~v;
			default: ret_val = v;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Edge generator.

	vpf_edge_gen #(.TICK_W(TICK_W)) u_gen
	(
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.ev(ev)
	);

	// The generator sees the software-written context directly.
	assign ev.run = st_ff.run;
	assign ev.period = st_ff.period;
	assign ev.edge_time = st_ff.edg;

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic: APB slave, vector take, pin drive and compare.
	always_comb
	begin
		logic setup;
		logic acc;
		logic drv;
		logic two;
		setup = psel && !penable;
		acc = psel && penable && st_ff.pready;
		drv = 1'b0;
		two = 1'b0;
		nxt_st = st_ff;
		nxt_st.pin_meta = pin_in;
		nxt_st.pin_sync = st_ff.pin_meta;
		nxt_st.fail = 1'b0;
		nxt_st.take = 1'b0;

		// The answer is prepared in the setup cycle so pready stands in access.
		nxt_st.pready = setup;
		nxt_st.pslverr = setup && !addr_ok(paddr);
		if (setup)
		begin
			case (paddr)
				A_CTRL:
					nxt_st.prdata = 32'({st_ff.mult, 1'b0, st_ff.fmt, st_ff.run});
				A_PERIOD:
					nxt_st.prdata = 32'(st_ff.period);
				A_STATUS:
					nxt_st.prdata = 32'({st_ff.run, st_ff.fail_cnt});
				default:
					nxt_st.prdata = is_edge(paddr) ? 32'(st_ff.edg[edge_idx(paddr)]) : 32'h0;
			endcase
		end

		// Writes land in the active context only; see [R12].
		if (acc && pwrite && addr_ok(paddr))
		begin
			case (paddr)
				A_CTRL:
				begin
					nxt_st.run = pwdata[CTRL_RUN];
					nxt_st.fmt = vpf_fmt_t'(pwdata[CTRL_FMT_LO +: 2]); // see [R1]
					nxt_st.mult = pwdata[CTRL_MULT_LO +: MULT_W]; // see [R10]
				end
				A_PERIOD:
					nxt_st.period = pwdata[TICK_W-1:0]; // see [R11]
				A_STATUS:
					nxt_st.fail_cnt = '0;
				default:
					nxt_st.edg[edge_idx(paddr)] = pwdata[TICK_W-1:0]; // see [R9]
			endcase
		end

		// At the period start the next vector and the format are taken.
		if (ev.start)
		begin
			nxt_st.take = 1'b1;
			nxt_st.act_fmt = st_ff.fmt;
			nxt_st.act_mult = st_ff.mult;
			nxt_st.cur_drv = vec_drive;
			nxt_st.nxt_drv = vec_next_drive;
			nxt_st.d1 = vec_data1;
			nxt_st.d2 = vec_data2;
			nxt_st.cmp = vec_cmp_en;
		end
		drv = nxt_st.cur_drv;
		two = nxt_st.act_mult >= MULT_TWO; // see [R10]

		// Drive edges; a later edge in the same tick wins.
		if (drv)
		begin
			if (ev.fire[E_EN] && !st_ff.pin_oe)
			begin
				nxt_st.pin_oe = 1'b1; // see [R2]
			end
			if (ev.fire[E_EN] && nxt_st.act_fmt == complement_surround_format)
			begin
				nxt_st.pin_oe = 1'b1;
				nxt_st.pin_out = ~nxt_st.d1; // see [R3]
			end
			if (ev.fire[E_DAT])
			begin
				nxt_st.pin_out = nxt_st.d1; // see [R4]
			end
			if (ev.fire[E_RET])
			begin
				nxt_st.pin_out = ret_val(nxt_st.act_fmt, nxt_st.d1); // see [R5]
			end
			if (two && ev.fire[E_DAT2])
			begin
				nxt_st.pin_out = nxt_st.d2; // see [R7]
			end
			if (two && ev.fire[E_RET2])
			begin
				nxt_st.pin_out = ret_val(nxt_st.act_fmt, nxt_st.d2); // see [R8]
			end
		end
		if (ev.fire[E_OFF] && !nxt_st.nxt_drv)
		begin
			nxt_st.pin_oe = 1'b0; // see [R6]
		end

		// Compare strobes on non-drive vectors check the synchronised pin.
		if (!drv && nxt_st.cmp)
		begin
			if (ev.fire[E_STB] && st_ff.pin_sync != nxt_st.d1)
			begin
				nxt_st.fail = 1'b1; // see [R13]
			end
			if (two && ev.fire[E_STB2] && st_ff.pin_sync != nxt_st.d2)
			begin
				nxt_st.fail = 1'b1; // see [R14]
			end
		end

		// A failure in the clearing cycle still counts; the count saturates.
		if (nxt_st.fail && nxt_st.fail_cnt != '1)
		begin
			nxt_st.fail_cnt = nxt_st.fail_cnt + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register.
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_ff <= '0;
			st_ff.period <= PERIOD_RST[TICK_W-1:0];
			st_ff.mult <= MULT_RST[MULT_W-1:0];
			st_ff.act_mult <= MULT_RST[MULT_W-1:0];
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	// Outputs come straight from the state register.
	assign prdata = st_ff.prdata;
	assign pready = st_ff.pready;
	assign pslverr = st_ff.pslverr;
	assign vec_take = st_ff.take;
	assign pin_out = st_ff.pin_out;
	assign pin_oe = st_ff.pin_oe;
	assign cmp_fail = st_ff.fail;

	////////////////////////////////////////////////////////////////////////////
	// Checks beside the logic.
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	AST_EN_ON: assert property ((ev.fire[E_EN] && !ev.start && st_ff.cur_drv && !st_ff.pin_oe &&
		!ev.fire[E_OFF]) |=> pin_oe) // see [R2]
		else $error("Driver not enabled at enable edge.");
	AST_SBC: assert property (($onehot(ev.fire) && ev.fire[E_EN] && !ev.start && st_ff.cur_drv &&
		st_ff.act_fmt == complement_surround_format) |=> (pin_out == ~$past(st_ff.d1) && pin_oe)) // see [R3]
		else $error("Complement not driven at enable edge.");
	AST_DATA: assert property (($onehot(ev.fire) && ev.fire[E_DAT] && !ev.start && st_ff.cur_drv)
		|=> pin_out == $past(st_ff.d1)) // see [R4]
		else $error("Pattern value not driven at data edge.");
	AST_RET_LOW: assert property (($onehot(ev.fire) && ev.fire[E_RET] && !ev.start &&
		st_ff.cur_drv && st_ff.act_fmt == return_low_format) |=> !pin_out) // see [R5]
		else $error("Return to low failed.");
	AST_OFF: assert property ((ev.fire[E_OFF] && !ev.start && !st_ff.nxt_drv) |=> !pin_oe) // see [R6]
		else $error("Driver not disabled at disable edge.");
	AST_DATA2: assert property (($onehot(ev.fire) && ev.fire[E_DAT2] && !ev.start &&
		st_ff.cur_drv && st_ff.act_mult >= MULT_TWO) |=> pin_out == $past(st_ff.d2)) // see [R7]
		else $error("Second value not driven.");
	AST_RET2_HIGH: assert property (($onehot(ev.fire) && ev.fire[E_RET2] && !ev.start &&
		st_ff.cur_drv && st_ff.act_fmt == return_high_format && st_ff.act_mult >= MULT_TWO)
		|=> pin_out) // see [R8]
		else $error("Second return to high failed.");
	AST_STROBE: assert property ((ev.fire[E_STB] && !ev.start && !st_ff.cur_drv && st_ff.cmp &&
		st_ff.pin_sync != st_ff.d1) |=> cmp_fail ##1 !cmp_fail) // see [R13]
		else $error("Strobe mismatch not flagged.");
	AST_TAKE: assert property (ev.start |=> vec_take ##1 !vec_take) // see [R11]
		else $error("Vector not taken at period start.");
	AST_APB: assert property ((psel && !penable) |=> pready)
		else $error("No answer in access phase.");

	CVR_FAIL: cover property (cmp_fail);
	CVR_SBC: cover property (ev.fire[E_EN] && st_ff.act_fmt == complement_surround_format);
	CVR_TWO: cover property (ev.fire[E_DAT2] && st_ff.act_mult >= MULT_TWO && st_ff.cur_drv);
endmodule

// file: tb/vpf_dut_model.sv
/*
 * Pin-side partner: a device under test that drives the shared pin while the
 * formatter's driver is off. Assumes pin_out and pin_oe come from the formatter.
 */
`timescale 1ns/1ps
module vpf_dut_model
(
	input wire logic pin_out,
	input wire logic pin_oe,
	input wire logic resp,
	output logic pin_in
);
	// The formatter owns the wire while its driver is on, else the device answers.
	assign pin_in = pin_oe ? pin_out : resp;
endmodule

// file: tb/testbench.sv
/*
 * Self-checking bench for the vector pin drive formatter.
 * Assumes the package, interface, design modules and pin model are compiled first.
 */
`timescale 1ns/1ps
module testbench;
	import vpf_pkg::*;
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, resp = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd_v;
	logic pready, pslverr, er_v, vec_take, pin_in, pin_out, pin_oe, cmp_fail;
	logic vec_drive = 1'b0, vec_next_drive = 1'b0, vec_data1 = 1'b0;
	logic vec_data2 = 1'b0, vec_cmp_en = 1'b0;
	int num_errors = 0;
	int comparisons = 0;
	int kk = 0;
	logic [15:0] edg [8] = '{16'h1, 16'h2, 16'h4, 16'hc, 16'h3, 16'h6, 16'h8, 16'h7};

	// Clock of 20 ns.
	always #10 clk_sys = ~clk_sys;

	vpf_formatter dut_u
	(
		.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .vec_drive(vec_drive),
		.vec_next_drive(vec_next_drive), .vec_data1(vec_data1),
		.vec_data2(vec_data2), .vec_cmp_en(vec_cmp_en), .vec_take(vec_take),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .cmp_fail(cmp_fail)
	);

	vpf_dut_model pin_u
	(
		.pin_out(pin_out), .pin_oe(pin_oe), .resp(resp), .pin_in(pin_in)
	);

	////////////////////////////////////////////////////////////////////////////
	// Compares one value, counts it and reports a mismatch.
	task automatic check(input string nm, input logic [31:0] ex, input logic [31:0] sn);
		comparisons++;
		if (sn !== ex)
		begin
			$display("[FAIL] %s expected %h seen %h", nm, ex, sn);
			num_errors++;
		end
	endtask

	// One APB transfer; the request stands until pready is sampled high.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1 && n < 50)
		begin
			@(posedge clk_sys);
			n++;
		end
		// A slave that never answers counts as a mismatch.
		if (n >= 50)
		begin
			$display("[FAIL] apb answer expected 1 seen %b", pready);
			num_errors++;
		end
		rd_v = prdata;
		er_v = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Sets run, format and edge multiplier.
	task automatic cfg(input vpf_fmt_t f, input logic [3:0] m);
		apb(1'b1, A_CTRL, {24'h0, m, 1'b0, f, 1'b1});
	endtask

	// Waits for a vector take, queues the next vector and stops one cycle on.
	task automatic wt(input logic dr, nx, d1, d2, ce);
		int n = 0;
		@(posedge clk_sys);
		while (vec_take !== 1'b1 && n < 100)
		begin
			@(posedge clk_sys);
			n++;
		end
		// A period start that never comes counts as a mismatch.
		if (n >= 100)
		begin
			$display("[FAIL] vec_take expected 1 seen %b", vec_take);
			num_errors++;
		end
		vec_drive <= dr;
		vec_next_drive <= nx;
		vec_data1 <= d1;
		vec_data2 <= d2;
		vec_cmp_en <= ce;
		#1;
		kk = 1;
	endtask

	// Moves to the cycle where an edge with offset k shows at the pin.
	task automatic go(input int k);
		repeat (k - kk) @(posedge clk_sys);
		#1;
		kk = k;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Reset values, unmapped access and the time set registers.
	task automatic t_reg;
		logic [7:0] ea;
		apb(1'b0, A_CTRL, 32'h0);
		check("ctrl reset", 32'h0000_0010, rd_v);
		apb(1'b0, A_STATUS, 32'h0);
		check("status reset", 32'h0, rd_v);
		apb(1'b1, 8'h2c, 32'hffff_ffff);
		check("unmapped write error", 1'b1, er_v);
		apb(1'b0, 8'h2c, 32'h0);
		check("unmapped read", 32'h0, rd_v);
		check("unmapped read error", 1'b1, er_v);
		for (int i = 0; i < 8; i++)
		begin
			ea = A_EDGE0 + 8'(i * 4);
			apb(1'b0, ea, 32'h0);
			check("edge reset", 32'h0, rd_v);
			apb(1'b1, ea, {16'hffff, edg[i]});
			apb(1'b0, ea, 32'h0);
			check("edge readback", {16'h0, edg[i]}, rd_v);
		end
		apb(1'b1, A_PERIOD, 32'hffff_0010);
		apb(1'b0, A_PERIOD, 32'h0);
		check("period readback", 32'h0000_0010, rd_v);
		$display("t_reg done");
	endtask

	// Every drive format, with the data flipped from the period before.
	task automatic t_fmt;
		logic [3:0] dv = 4'b1011;
		logic [3:0] x1 = 4'b0100;
		logic [3:0] x4 = 4'b0101;
		for (int f = 0; f < 4; f++)
		begin
			cfg(vpf_fmt_t'(f), MULT_RST);
			repeat (3) wt(1'b1, 1'b1, ~dv[f], ~dv[f], 1'b0);
			repeat (2) wt(1'b1, 1'b1, dv[f], dv[f], 1'b0);
			check("pin before data", x1[f], pin_out);
			check("driver on", 1'b1, pin_oe);
			go(2);
			check("pin at data", dv[f], pin_out);
			go(4);
			check("pin at return", x4[f], pin_out);
		end
		$display("t_fmt done");
	endtask

	// Driver off before a non-drive vector, back on at the enable edge.
	task automatic t_off;
		cfg(non_return_format, MULT_RST);
		repeat (2) wt(1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
		wt(1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
		wt(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
		go(11);
		check("oe before off", 1'b1, pin_oe);
		go(12);
		check("oe after off", 1'b0, pin_oe);
		wt(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
		go(4);
		check("oe on non-drive", 1'b0, pin_oe);
		wt(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
		check("oe at enable", 1'b1, pin_oe);
		check("pin held", 1'b1, pin_out);
		go(2);
		check("pin at data", 1'b0, pin_out);
		$display("t_off done");
	endtask

	// Two packed cycles, and the second edges ignored with one.
	task automatic t_pk;
		vpf_fmt_t fm [3] = '{return_low_format, return_high_format, return_low_format};
		logic [3:0] ml [3] = '{MULT_TWO, MULT_TWO, MULT_RST};
		logic [2:0] d2 = 3'b101;
		logic [2:0] e4 = 3'b010;
		logic [2:0] e6 = 3'b001;
		logic [2:0] e8 = 3'b010;
		for (int i = 0; i < 3; i++)
		begin
			cfg(fm[i], ml[i]);
			repeat (3) wt(1'b1, 1'b1, 1'b1, d2[i], 1'b0);
			go(4);
			check("pin at return", e4[i], pin_out);
			go(6);
			check("pin at second data", e6[i], pin_out);
			go(8);
			check("pin at second return", e8[i], pin_out);
		end
		$display("t_pk done");
	endtask

	// Strobes on compare vectors: first and second cycle, masked, single cycle.
	task automatic t_stb;
		logic [3:0] rs = 4'b0101;
		logic [3:0] ce = 4'b1011;
		logic [3:0] ec = 4'b0011;
		logic [3:0] el = 4'b0010;
		int n;
		int late;
		wt(1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
		for (int i = 0; i < 4; i++)
		begin
			cfg(non_return_format, (i == 3) ? MULT_RST : MULT_TWO);
			resp <= rs[i];
			repeat (3) wt(1'b0, 1'b0, 1'b0, 1'b1, ce[i]);
			n = 0;
			late = 0;
			for (int k = 1; k < 16; k++)
			begin
				n += (cmp_fail === 1'b1);
				late += (cmp_fail === 1'b1 && k >= 5);
				@(posedge clk_sys);
				#1;
			end
			check("fail pulses", ec[i], n);
			check("second cycle fail pulses", el[i], late);
		end
		apb(1'b0, A_STATUS, 32'h0);
		check("fail count kept", 1'b1, rd_v[15:0] != 16'h0);
		apb(1'b1, A_STATUS, 32'h0);
		apb(1'b0, A_STATUS, 32'h0);
		check("status after clear", 32'h0001_0000, rd_v);
		$display("t_stb done");
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Prints the counts and the verdict, then ends the run.
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Main sequence after a reset of 12 cycles.
	initial
	begin
		repeat (12) @(posedge clk_sys);
		arst_n <= 1'b1;
		t_reg;
		t_fmt;
		t_off;
		t_pk;
		t_stb;
		final_report;
	end

	// Cuts a hang short well after the thousand or so cycles the tests need.
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		num_errors++;
		final_report;
	end
endmodule
